// >>> dv/bcr_host_model.sv
// Host-side bus master model driving the two-wire register port.
// Assumes the bench resolves the open-drain data wire with a pull-up; bit period 64 ns.
module bcr_host_model
   import bcr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       sda_wire,
   output logic            scl,
   output logic            sda_pull,
   output logic [7:0]      rd_data,
   output logic            rd_stb
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
      rd_data  = 8'h00;
      rd_stb   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Data moves only well after the clock fall, so no false start or stop is seen
   task automatic start_cond();
      tick(4);
      sda_pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_pull = 1'b1;
      tick(8);
      scl = 1'b0;
   endtask

   task automatic stop_cond();
      tick(4);
      sda_pull = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_pull = 1'b0;
      tick(8);
   endtask

   task automatic put_bit(input logic b);
      tick(4);
      sda_pull = ~b;
      tick(4);
      scl = 1'b1;
      tick(8);
      scl = 1'b0;
   endtask

   task automatic get_bit(output logic b);
      tick(4);
      sda_pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      b = sda_wire;
      tick(4);
      scl = 1'b0;
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask

   task automatic write_reg(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start_cond();
      put_byte({dev, 1'b0}, a0);
      put_byte(r, a1);
      put_byte(d, a2);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask

   task automatic read_regs(input logic [7:0] r, input int n, output logic ok);
      logic       a0, a1, a2, b;
      logic [7:0] v;
      start_cond();
      put_byte({SLAVE_ADDR, 1'b0}, a0);
      put_byte(r, a1);
      start_cond();
      put_byte({SLAVE_ADDR, 1'b1}, a2);
      for (int k = 0; k < n; k++)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            get_bit(b);
            v[i] = b;
         end
         rd_data = v;
         rd_stb  = 1'b1;
         tick(1);
         rd_stb  = 1'b0;
         put_bit(k == n - 1);
      end
      stop_cond();
      ok = a0 & a1 & a2;
   endtask
endmodule

// >>> dv/buck_control_status_regs_tb.sv
// Self-checking bench for the regulator register block over the two-wire port.
// Assumes bcr_host_model as bus master; pins change at the falling mclk edge.
module buck_control_status_regs_tb import bcr_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [6:0] CODE_RST = 7'h50;
   localparam logic [6:0] CODE_HRST = 7'h2A;
   localparam logic [2:0] VEND = 3'h6;   // Arbitrary value
   localparam logic [3:0] DIE = 4'h9;    // Arbitrary value
   localparam logic [3:0] REV = 4'hA;    // Arbitrary value
   localparam logic [7:0] IDV_X = {VEND, 1'b0, DIE};
   localparam logic [7:0] IDR_X = {4'h0, REV};

   logic       mclk, reset_n, scl, sda_pull, sda_wire, rd_stb, sda_out, sda_oe, ok;
   logic       en_pin, select_pin, input_low_flag_in, ovp_in, thermal_in, ss_done, at_target;
   logic       buck_on, fpwm_mode, discharge_en;
   logic [6:0] vout_code, code;
   logic [2:0] slew_code;
   logic [7:0] rd_data, d;
   logic [7:0] exp_q [$];
   int         n_mismatch, checks_done, seed, rnd;

   assign sda_wire = sda_oe ? sda_out : ~sda_pull;

   bcr_regs #(.CODE_LOW_RST(CODE_RST), .CODE_HIGH_RST(CODE_HRST), .VENDOR_CODE(VEND), .DIE_CODE(DIE),
      .DIE_REV(REV)) u_dut (
      .mclk(mclk), .reset_n(reset_n), .scl_pin(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .en_pin(en_pin), .select_pin(select_pin), .input_low_flag_in(input_low_flag_in), .ovp_in(ovp_in),
      .thermal_in(thermal_in), .softstart_done_in(ss_done), .at_target_in(at_target),
      .buck_on(buck_on), .fpwm_mode(fpwm_mode), .vout_code(vout_code), .slew_code(slew_code),
      .discharge_en(discharge_en));

   bcr_host_model u_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull),
      .rd_data(rd_data), .rd_stb(rd_stb));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] r, input logic [7:0] v);
      u_host.write_reg(SLAVE_ADDR, r, v, ok);
      cmp("write_ack", 8'h01, {7'h00, ok});
   endtask

   // Expected bytes are queued before the read starts
   task automatic rd(input logic [7:0] r, input logic [7:0] e [$]);
      foreach (e[i]) exp_q.push_back(e[i]);
      u_host.read_regs(r, e.size(), ok);
      cmp("read_ack", 8'h01, {7'h00, ok});
   endtask

   task automatic settle();
      repeat (10) @(negedge mclk);
   endtask

   task automatic pins(input logic on, input logic fp, input logic [6:0] vc);
      settle();
      cmp("buck_on", {7'h00, on}, {7'h00, buck_on});
      cmp("fpwm_mode", {7'h00, fp}, {7'h00, fpwm_mode});
      cmp("vout_code", {1'b0, vc}, {1'b0, vout_code});
   endtask

   // Read bytes are checked against the oldest queued note
   always @(posedge mclk)
   begin
      if (rd_stb === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp("unexpected_read", 8'h00, rd_data);
         else
            cmp("read_byte", exp_q.pop_front(), rd_data);
      end
   end

   initial
   begin
      repeat (100000) @(posedge mclk);
      n_mismatch++;
      conclude();
   end

   initial
   begin
      seed = 32'hafe4;
      n_mismatch = 0;
      checks_done = 0;
      reset_n = 1'b0;
      en_pin = 1'b1;
      select_pin = 1'b0;
      input_low_flag_in = 1'b0;
      ovp_in = 1'b0;
      thermal_in = 1'b0;
      ss_done = 1'b1;
      at_target = 1'b1;
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      repeat (5) @(negedge mclk);
      pins(1'b1, 1'b0, CODE_RST);
      rd(A_VLOW, '{{1'b1, CODE_RST}, {1'b1, CODE_HRST}, 8'h82, IDV_X, IDR_X, 8'h81, 8'h00});
      // Every slew code, every mode value at both select levels
      for (int i = 0; i < 8; i++)
      begin
         d = {i[0], i[2:0], 1'b1, 1'b0, i[1:0]};
         select_pin = i[2];
         wr(A_CTRL, d);
         settle();
         cmp("slew_code", {5'h00, i[2:0]}, {5'h00, slew_code});
         cmp("discharge_en", {7'h00, i[0]}, {7'h00, discharge_en});
         cmp("fpwm_mode", {7'h00, i[2] ? i[1] : i[0]}, {7'h00, fpwm_mode});
         rd(A_CTRL, '{d & 8'hF3});
      end
      rnd = $random(seed);
      code = rnd[6:0];
      wr(A_VHIGH, {1'b0, code});
      pins(1'b0, 1'b1, code);
      wr(A_VHIGH, {1'b1, code});
      pins(1'b1, 1'b1, code);
      en_pin = 1'b0;
      pins(1'b0, 1'b1, code);
      en_pin = 1'b1;
      rd(A_VHIGH, '{{1'b1, code}});
      select_pin = 1'b0;
      {input_low_flag_in, ovp_in, thermal_in, ss_done} = 4'hE;
      settle();
      rd(A_MON, '{8'h73});
      en_pin = 1'b0;
      settle();
      rd(A_MON, '{8'h62});
      {en_pin, input_low_flag_in, ovp_in, thermal_in, ss_done} = 5'h11;
      at_target = 1'b0;
      wr(A_VLOW, 8'hE0);
      rd(A_MON, '{8'h91});
      wr(A_VLOW, 8'h90);
      rd(A_MON, '{8'h89});
      at_target = 1'b1;
      settle();
      rd(A_MON, '{8'h81});
      wr(A_IDVEN, 8'hFF);
      wr(A_IDREV, 8'hFF);
      wr(A_MON, 8'hFF);
      rd(A_IDVEN, '{IDV_X, IDR_X, 8'h81});
      u_host.write_reg(SLAVE_ADDR ^ 7'h01, A_VLOW, 8'h00, ok);
      cmp("foreign_ack", 8'h00, {7'h00, ok});
      rd(A_VLOW, '{8'h90});
      wr(A_CTRL, 8'h04);
      pins(1'b1, 1'b0, CODE_RST);
      rd(A_VLOW, '{{1'b1, CODE_RST}, {1'b1, CODE_HRST}, 8'h82, IDV_X, IDR_X, 8'h85});
      rd(A_MON, '{8'h81});
      if (exp_q.size() != 0)
         n_mismatch++;
      conclude();
   end
endmodule

// >>> rtl/bcr_pkg.sv
// Constants, types and encodings shared by the regulator register block.
// Assumes a single mclk domain; pins are synchronised before use.
// What this block does
// - High-select software enable bit 7, default one
// - High-select bits 6:0 hold voltage code
// - Control bit 7 selects output discharge
// - Control bits 6:4 select rising slew code
// - Reserved control and identity bits read zero
// - Control bit 2 restores defaults, reads zero
// - Mode bit per select level forces PWM
// - First identity: vendor 7:5, die 3:0
// - Second identity: zero nibble, revision nibble
// - Monitor bit 7: enabled and soft-start done
// - Monitor bit 6: input below lockout
// - Monitor bit 5: input above overvoltage
// - Monitor bit 4: rising transition or soft-start
// - Monitor bit 3: falling transition in progress
// - Monitor bit 2: register reset, cleared by read
// - Monitor bit 1: thermal shutdown active
// - Monitor bit 0: converter enable state
// - Select pin picks low or high code
// - Slew code halves rate per step
// - Output on needs enable pin and bit
// - Serial slave at address C0, R/W LSB
package bcr_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h60;
   localparam logic [7:0] A_VLOW     = 8'h00;
   localparam logic [7:0] A_VHIGH    = 8'h01;
   localparam logic [7:0] A_CTRL     = 8'h02;
   localparam logic [7:0] A_IDVEN    = 8'h03;
   localparam logic [7:0] A_IDREV    = 8'h04;
   localparam logic [7:0] A_MON      = 8'h05;
   localparam int         B_SWEN     = 7;
   localparam int         B_DIS      = 7;
   localparam int         B_SLEW     = 4;
   localparam int         B_SRST     = 2;
   localparam logic       RST_SWEN   = 1'b1;
   localparam logic       RST_DIS    = 1'b1;
   localparam logic [2:0] RST_SLEW   = 3'h0;
   localparam logic [1:0] RST_MODE   = 2'h2;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_REG, S_RACK, S_WDATA, S_WACK, S_RDATA, S_RDACK
   } bcr_i2c_e;

   typedef struct packed {
      bcr_i2c_e   st;
      logic       scl_p;
      logic       sda_p;
      logic       full;
      logic       rw;
      logic       oe;
      logic       sda_o;
      logic [2:0] cnt;
      logic [7:0] shf;
      logic [7:0] ptr;
      logic       swen_l;
      logic       swen_h;
      logic [6:0] code_l;
      logic [6:0] code_h;
      logic       dis;
      logic [2:0] slew;
      logic [1:0] mode;
      logic       rst_stat;
      logic       on;
      logic       fpwm;
      logic       dis_o;
      logic [6:0] vcode;
      logic [2:0] slew_o;
   } bcr_top_s;
endpackage

// >>> rtl/bcr_regs.sv
// Regulator control/status registers behind a serial two-wire slave.
// Assumes scl/sda and analogue flags are asynchronous pins; sda is open drain.
module bcr_regs
   import bcr_pkg::*;
#(
   parameter logic [6:0] CODE_LOW_RST  = 7'h50,
   parameter logic [6:0] CODE_HIGH_RST = 7'h50,
   parameter logic [2:0] VENDOR_CODE   = 3'h2,   // Arbitrary value
   parameter logic [3:0] DIE_CODE      = 4'h5,   // Arbitrary value
   parameter logic [3:0] DIE_REV       = 4'h3    // Arbitrary value
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       scl_pin,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       en_pin,
   input  wire logic       select_pin,
   input  wire logic       input_low_flag_in,
   input  wire logic       ovp_in,
   input  wire logic       thermal_in,
   input  wire logic       softstart_done_in,
   input  wire logic       at_target_in,
   output logic            buck_on,
   output logic            fpwm_mode,
   output logic [6:0]      vout_code,
   output logic [2:0]      slew_code,
   output logic            discharge_en
);
   localparam bcr_top_s TOP_RST = '{
      st: S_IDLE, scl_p: 1'b0, sda_p: 1'b0, full: 1'b0, rw: 1'b0, oe: 1'b0, sda_o: 1'b0,
      cnt: 3'h0, shf: 8'h00, ptr: 8'h00, swen_l: RST_SWEN, swen_h: RST_SWEN,
      code_l: CODE_LOW_RST, code_h: CODE_HIGH_RST, dis: RST_DIS, slew: RST_SLEW,
      mode: RST_MODE, rst_stat: 1'b0, on: 1'b0, fpwm: 1'b0, dis_o: RST_DIS,
      vcode: CODE_LOW_RST, slew_o: RST_SLEW};

   bcr_top_s   q;
   bcr_top_s   n;
   logic [8:0] sync_q;
   logic       scl_s;
   logic       sda_s;
   logic       scl_r;
   logic       scl_f;
   logic       start;
   logic       stop;
   logic       wr_ev;
   logic       ld_ev;
   logic [7:0] ld_addr;
   logic [7:0] ctrl_rd;
   logic [7:0] vend_rd;
   logic [7:0] mon_rd;
   bcr_stat_if sif ();

   bcr_sync #(.W(9)) u_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .d       ({scl_pin, sda_in, en_pin, select_pin, input_low_flag_in, ovp_in, thermal_in,
                 softstart_done_in, at_target_in}),
      .q       (sync_q)
   );

   bcr_status_mon u_mon (
      .mclk    (mclk),
      .reset_n (reset_n),
      .sif     (sif)
   );

   assign scl_s       = sync_q[8];
   assign sda_s       = sync_q[7];
   assign sif.en      = sync_q[6];
   assign sif.sel     = sync_q[5];
   assign sif.input_low_flag    = sync_q[4];
   assign sif.input_high_flag     = sync_q[3];
   assign sif.ot      = sync_q[2];
   assign sif.ss_done = sync_q[1];
   assign sif.at_tgt  = sync_q[0];
   assign sif.swen_l  = q.swen_l;
   assign sif.swen_h  = q.swen_h;
   assign sif.code_l  = q.code_l;
   assign sif.code_h  = q.code_h;

   // Bus events from synchronised pins
   assign scl_r = scl_s & ~q.scl_p;
   assign scl_f = ~scl_s & q.scl_p;
   assign start = scl_s & q.scl_p & q.sda_p & ~sda_s;
   assign stop  = scl_s & q.scl_p & ~q.sda_p & sda_s;
   assign wr_ev = scl_f & q.full & (q.st == S_WDATA);
   assign ld_ev = scl_f & ((q.st == S_AACK & q.rw) | (q.st == S_RDACK & ~q.full));
   assign ld_addr = (q.st == S_RDACK) ? q.ptr + 8'h01 : q.ptr;

   // Read value of a register
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         A_VLOW:  v = {q.swen_l, q.code_l};
         A_VHIGH: v = {q.swen_h, q.code_h};
         A_CTRL:  v = {q.dis, q.slew, 1'b0, 1'b0, q.mode};
         A_IDVEN: v = {VENDOR_CODE, 1'b0, DIE_CODE};
         A_IDREV: v = {4'h0, DIE_REV};
         A_MON:   v = {sif.regulation_ok, sif.f_input_low_flag, sif.f_ovp, sif.pos, sif.neg,
                       q.rst_stat, sif.f_ot, sif.on};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Register views seen by the checks
   always_comb
   begin
      ctrl_rd = rd_byte(A_CTRL);
      vend_rd = rd_byte(A_IDVEN);
      mon_rd  = rd_byte(A_MON);
   end

   always_comb
   begin
      n        = q;
      n.scl_p  = scl_s;
      n.sda_p  = sda_s;
      n.on     = sif.on;
      n.fpwm   = sif.sel ? q.mode[1] : q.mode[0];
      n.vcode  = sif.code_sel;
      n.slew_o = q.slew;
      n.dis_o  = q.dis;
      if (scl_r)
      begin
         if (q.st == S_ADDR || q.st == S_REG || q.st == S_WDATA || q.st == S_RDATA)
         begin
            if (q.st != S_RDATA)
               n.shf = {q.shf[6:0], sda_s};
            n.cnt  = q.cnt + 3'h1;
            n.full = (q.cnt == 3'h7);
         end
         else if (q.st == S_RDACK)
            n.full = sda_s;
      end
      if (scl_f)
      begin
         case (q.st)
            S_ADDR:
            begin
               if (q.full)
               begin
                  n.full = 1'b0;
                  if (q.shf[7:1] == SLAVE_ADDR)
                  begin
                     n.rw = q.shf[0];
                     n.st = S_AACK;
                     n.oe = 1'b1;
                  end
                  else
                     n.st = S_IDLE;
               end
            end
            S_AACK:
            begin
               n.cnt = 3'h0;
               if (q.rw)
               begin
                  n.st  = S_RDATA;
                  n.shf = rd_byte(ld_addr);
                  n.oe  = ~n.shf[7];
               end
               else
               begin
                  n.st = S_REG;
                  n.oe = 1'b0;
               end
            end
            S_REG:
            begin
               if (q.full)
               begin
                  n.full = 1'b0;
                  n.ptr  = q.shf;
                  n.st   = S_RACK;
                  n.oe   = 1'b1;
               end
            end
            S_RACK, S_WACK:
            begin
               n.st = S_WDATA;
               n.oe = 1'b0;
            end
            S_WDATA:
            begin
               if (q.full)
               begin
                  n.full = 1'b0;
                  n.ptr  = q.ptr + 8'h01;
                  n.st   = S_WACK;
                  n.oe   = 1'b1;
                  case (q.ptr)
                     A_VLOW:
                     begin
                        n.swen_l = q.shf[B_SWEN];
                        n.code_l = q.shf[6:0];
                     end
                     A_VHIGH:
                     begin
                        n.swen_h = q.shf[B_SWEN];
                        n.code_h = q.shf[6:0];
                     end
                     A_CTRL:
                     begin
                        if (q.shf[B_SRST])
                        begin
                           n.swen_l   = RST_SWEN;
                           n.swen_h   = RST_SWEN;
                           n.code_l   = CODE_LOW_RST;
                           n.code_h   = CODE_HIGH_RST;
                           n.dis      = RST_DIS;
                           n.slew     = RST_SLEW;
                           n.mode     = RST_MODE;
                           n.rst_stat = 1'b1;
                        end
                        else
                        begin
                           n.dis  = q.shf[B_DIS];
                           n.slew = q.shf[B_SLEW +: 3];
                           n.mode = q.shf[1:0];
                        end
                     end
                     default: n.ptr = q.ptr + 8'h01;
                  endcase
               end
            end
            S_RDATA:
            begin
               if (q.full)
               begin
                  n.full = 1'b0;
                  n.st   = S_RDACK;
                  n.oe   = 1'b0;
               end
               else
               begin
                  n.shf = {q.shf[6:0], 1'b0};
                  n.oe  = ~q.shf[6];
               end
            end
            S_RDACK:
            begin
               if (q.full)
               begin
                  n.full = 1'b0;
                  n.st   = S_IDLE;
               end
               else
               begin
                  n.ptr = ld_addr;
                  n.cnt = 3'h0;
                  n.st  = S_RDATA;
                  n.shf = rd_byte(ld_addr);
                  n.oe  = ~n.shf[7];
               end
            end
            default: n.st = q.st;
         endcase
      end
      if (ld_ev && ld_addr == A_MON && !wr_ev)
         n.rst_stat = 1'b0;
      if (start)
      begin
         n.st   = S_ADDR;
         n.cnt  = 3'h0;
         n.full = 1'b0;
         n.oe   = 1'b0;
      end
      else if (stop)
      begin
         n.st = S_IDLE;
         n.oe = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         q <= TOP_RST;
      else
         q <= n;
   end

   assign sda_out      = q.sda_o;
   assign sda_oe       = q.oe;
   assign buck_on      = q.on;
   assign fpwm_mode    = q.fpwm;
   assign vout_code    = q.vcode;
   assign slew_code    = q.slew_o;
   assign discharge_en = q.dis_o;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   chk_soft_reset: assert property (wr_ev && q.ptr == A_CTRL && q.shf[B_SRST]
      |=> q.swen_h && q.mode == RST_MODE && q.rst_stat && q.dis ##1 discharge_en)
      else $error("soft reset did not restore defaults");
   chk_vhigh_write: assert property (wr_ev && q.ptr == A_VHIGH
      |=> q.code_h == $past(q.shf[6:0]) && q.swen_h == $past(q.shf[7]))
      else $error("high-select write lost");
   chk_rsvd_zero: assert property (ctrl_rd[3:2] == 2'b00 && !vend_rd[4])
      else $error("reserved bit not zero");
   chk_ro_write: assert property (wr_ev && q.ptr >= A_IDVEN
      |=> $stable(q.code_h) && $stable(q.mode) && $stable(q.rst_stat))
      else $error("read-only write changed state");
   chk_rstat_clear: assert property (ld_ev && ld_addr == A_MON && q.rst_stat
      |=> !q.rst_stat)
      else $error("reset flag not cleared by read");
   chk_addr_ack: assert property (scl_f && q.st == S_ADDR && q.full && q.shf[7:1] == SLAVE_ADDR
      |=> sda_oe && q.st == S_AACK)
      else $error("own address not acknowledged");
   chk_addr_miss: assert property (scl_f && q.st == S_ADDR && q.full && q.shf[7:1] != SLAVE_ADDR
      |=> !sda_oe && q.st == S_IDLE)
      else $error("foreign address answered");
   chk_mode_pick: assert property (##1 fpwm_mode == $past(sif.sel ? q.mode[1] : q.mode[0]))
      else $error("mode bit not taken by select level");
   chk_buck_on: assert property ($rose(sif.on) |=> buck_on && mon_rd[0])
      else $error("enable state not reported");
   chk_ctrl_write: assert property (wr_ev && q.ptr == A_CTRL && !q.shf[B_SRST]
      |=> q.dis == $past(q.shf[B_DIS]) && q.slew == $past(q.shf[B_SLEW +: 3]) && q.mode == $past(q.shf[1:0]))
      else $error("control write lost");
   chk_slew_out: assert property (##1 slew_code == $past(q.slew))
      else $error("slew code not presented");
   chk_dis_out: assert property (##1 discharge_en == $past(q.dis))
      else $error("discharge bit not presented");
   chk_wdata_ack: assert property (scl_f && q.st == S_WDATA && q.full
      |=> sda_oe && q.st == S_WACK)
      else $error("data byte not acknowledged");
   chk_rd_release: assert property (scl_f && q.st == S_RDATA && q.full
      |=> !sda_oe && q.st == S_RDACK)
      else $error("data line not released for master acknowledge");
   chk_nack_idle: assert property (scl_f && q.st == S_RDACK && q.full
      |=> q.st == S_IDLE)
      else $error("read not ended on master refusal");

   cov_ctrl_write: cover property (wr_ev && q.ptr == A_CTRL && !q.shf[B_SRST]);
   cov_soft_reset: cover property (wr_ev && q.ptr == A_CTRL && q.shf[B_SRST]);
   cov_mon_read:   cover property (ld_ev && ld_addr == A_MON && q.rst_stat);
   cov_foreign:    cover property (scl_f && q.st == S_ADDR && q.full && q.shf[7:1] != SLAVE_ADDR);
   cov_rd_burst:   cover property (ld_ev && q.st == S_RDACK);
endmodule

// >>> rtl/bcr_stat_if.sv
// Carrier between the register file and the status monitor.
// Assumes both ends run on mclk.
interface bcr_stat_if;
   logic       en;
   logic       sel;
   logic       swen_l;
   logic       swen_h;
   logic [6:0] code_l;
   logic [6:0] code_h;
   logic       input_low_flag;
   logic       input_high_flag;
   logic       ot;
   logic       ss_done;
   logic       at_tgt;
   logic       on;
   logic       regulation_ok;
   logic       pos;
   logic       neg;
   logic [6:0] code_sel;
   logic       f_input_low_flag;
   logic       f_ovp;
   logic       f_ot;
   modport regs (output en, sel, swen_l, swen_h, code_l, code_h, input_low_flag, input_high_flag, ot, ss_done, at_tgt,
                 input on, regulation_ok, pos, neg, code_sel, f_input_low_flag, f_ovp, f_ot);
   modport mon  (input en, sel, swen_l, swen_h, code_l, code_h, input_low_flag, input_high_flag, ot, ss_done, at_tgt,
                 output on, regulation_ok, pos, neg, code_sel, f_input_low_flag, f_ovp, f_ot);
endinterface

// >>> rtl/bcr_status_mon.sv
// Live status: converter enable, power good, transition direction.
// Assumes all interface inputs are already synchronous to mclk.
module bcr_status_mon (
   input  wire logic mclk,
   input  wire logic reset_n,
   bcr_stat_if.mon   sif
);
   typedef struct packed {
      logic       on;
      logic       up;
      logic       dn;
      logic [6:0] code;
      logic       regulation_ok;
      logic       pos;
      logic       neg;
      logic       input_low_flag;
      logic       input_high_flag;
      logic       ot;
   } bcr_mon_s;
   bcr_mon_s m_q;
   bcr_mon_s m_d;
   logic     on_n;
   logic [6:0] code_n;

   always_comb
   begin
      on_n   = sif.en & (sif.sel ? sif.swen_h : sif.swen_l);
      code_n = sif.sel ? sif.code_h : sif.code_l;
      m_d      = m_q;
      m_d.on   = on_n;
      m_d.code = code_n;
      if (!on_n)
      begin
         m_d.up = 1'b0;
         m_d.dn = 1'b0;
      end
      else if (code_n > m_q.code)
      begin
         m_d.up = 1'b1;
         m_d.dn = 1'b0;
      end
      else if (code_n < m_q.code)
      begin
         m_d.up = 1'b0;
         m_d.dn = 1'b1;
      end
      else if (sif.at_tgt)
      begin
         m_d.up = 1'b0;
         m_d.dn = 1'b0;
      end
      m_d.regulation_ok = on_n & sif.ss_done;
      m_d.pos   = on_n & (~sif.ss_done | m_d.up);
      m_d.neg   = on_n & m_d.dn;
      m_d.input_low_flag  = sif.input_low_flag;
      m_d.input_high_flag   = sif.input_high_flag;
      m_d.ot    = sif.ot;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         m_q <= '0;
      else
         m_q <= m_d;
   end

   assign sif.on       = m_q.on;
   assign sif.regulation_ok    = m_q.regulation_ok;
   assign sif.pos      = m_q.pos;
   assign sif.neg      = m_q.neg;
   assign sif.code_sel = m_q.code;
   assign sif.f_input_low_flag   = m_q.input_low_flag;
   assign sif.f_ovp    = m_q.input_high_flag;
   assign sif.f_ot     = m_q.ot;
endmodule

// >>> rtl/bcr_sync.sv
// Two-stage synchroniser for a bus of asynchronous levels.
// Assumes inputs may change at any time relative to mclk.
module bcr_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bcr_sync_s;
   bcr_sync_s r_q;
   bcr_sync_s r_d;

   always_comb
   begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   assign q = r_q.s2;
endmodule
